//--- hw/wasc_map.vh
// register map, field positions, reset values and timing constants of the web aux speed control
`ifndef WASC_MAP_VH
`define WASC_MAP_VH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define WASC_CTRL_OFS        12'h000
`define WASC_DEV_THR_OFS     12'h004
`define WASC_ESTOP_TIME_OFS  12'h008
`define WASC_INCH_SPD_OFS    12'h00C
`define WASC_INCH_ACC_OFS    12'h010
`define WASC_INCH_DEC_OFS    12'h014
`define WASC_BASE_ACC_OFS    12'h018
`define WASC_BASE_DEC_OFS    12'h01C
`define WASC_SPLICE_OFS      12'h020
`define WASC_MAX_SPD_OFS     12'h024
`define WASC_LINE_CMD_OFS    12'h028
`define WASC_STATUS_OFS      12'h02C
`define WASC_IRQ_STAT_OFS    12'h030
`define WASC_IRQ_MASK_OFS    12'h034
`define WASC_SPD_REF_OFS     12'h038

// ****************************************************************
// control fields
// ****************************************************************
`define WASC_CTRL_DEV_EN     0
`define WASC_CTRL_INCH_SEL   1
`define WASC_CTRL_OUT1_DEV   2
`define WASC_CTRL_OC_DEV     3

// status / irq fields
`define WASC_ST_DEV          0
`define WASC_ST_ESTOP        1
`define WASC_ST_STOPPED      2
`define WASC_ST_INCH         3
`define WASC_ST_SPLICE       4
`define WASC_ST_TENSION      5
`define WASC_ST_DIAM         6

// ****************************************************************
// reset values (percent in 0.1 units, times in 0.01 s units)
// ****************************************************************
`define WASC_CTRL_RST        4'h2
`define WASC_DEV_THR_RST     16'h0000
`define WASC_ESTOP_TIME_RST  20'h0_0064
`define WASC_INCH_SPD_RST    16'h0064
`define WASC_INCH_ACC_RST    20'h0_01F4
`define WASC_INCH_DEC_RST    20'h0_01F4
`define WASC_BASE_ACC_RST    20'h0_01F4
`define WASC_BASE_DEC_RST    20'h0_01F4
`define WASC_SPLICE_RST      16'h0000
`define WASC_MAX_SPD_RST     16'h0BB8
`define WASC_PCT_MAX         16'h03E8
`define WASC_HYST_PCT        16'h0014
`define WASC_STATUS_RST      7'h60

// ****************************************************************
// timing: one time unit is 10 ms at a 4 ns clock
// ****************************************************************
`define WASC_TICK_NS         10000000
`define WASC_CLK_NS          4
`define WASC_TICK_CYC        (`WASC_TICK_NS / `WASC_CLK_NS)

`endif

//--- hw/wasc_sync2.v
// two-flop synchroniser for one asynchronous level
`timescale 1ns/100ps
module wasc_sync2 (
	input  wire pclk,
	input  wire presetn,
	input  wire d,
	output wire q
);
	reg meta_q;
	reg sync_q;

	// first stage feeds only the second stage
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
		end else begin
			meta_q <= d;
			sync_q <= meta_q;
		end
	end

	assign q = sync_q;
endmodule

//--- hw/wasc_top.v
// web aux speed control: deviation flag, emergency ramp, inching, splice boost, apb registers
`timescale 1ns/100ps
`include "wasc_map.vh"
module wasc_top #(
	parameter TICK_CYC = `WASC_TICK_CYC
) (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	input  wire        estop_in,
	input  wire        inch_in,
	input  wire        tension_loop_inhibit,
	input  wire        splice_in,
	input  wire [15:0] line_speed_actual,
	output reg  [15:0] speed_ref,
	output wire        speed_deviation_output,
	output wire        aux_output_one,
	output wire        open_collector_output,
	output wire        tension_ctrl_run,
	output wire        diameter_calc_run,
	output wire        irq
);
	// ****************************************************************
	// pin synchronisers
	// ****************************************************************
	wire estop_s;
	wire inch_s;
	wire tinh_s;
	wire splice_s;

	// each control pin passes two flops; nothing but the second stage reads the first
	wasc_sync2 u_sync_estop  (.pclk(pclk), .presetn(presetn), .d(estop_in),             .q(estop_s));
	wasc_sync2 u_sync_inch   (.pclk(pclk), .presetn(presetn), .d(inch_in),              .q(inch_s));
	wasc_sync2 u_sync_tinh   (.pclk(pclk), .presetn(presetn), .d(tension_loop_inhibit), .q(tinh_s));
	wasc_sync2 u_sync_splice (.pclk(pclk), .presetn(presetn), .d(splice_in),            .q(splice_s));

	// actual speed is a bus from another domain; each bit is synchronised, a brief skew is tolerable
	reg [15:0] act_meta_q;
	reg [15:0] act_q;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			act_meta_q <= 16'h0000;
			act_q      <= 16'h0000;
		end else begin
			act_meta_q <= line_speed_actual;
			act_q      <= act_meta_q;
		end
	end

	// ****************************************************************
	// registers
	// ****************************************************************
	// configuration held in flip-flops, reset to the factory settings
	reg  [3:0]  ctrl_q;
	reg  [15:0] dev_thr_q;
	reg  [19:0] estop_time_q;
	reg  [15:0] inch_spd_q;
	reg  [19:0] inch_acc_q;
	reg  [19:0] inch_dec_q;
	reg  [19:0] base_acc_q;
	reg  [19:0] base_dec_q;
	reg  [15:0] splice_q;
	reg  [15:0] max_spd_q;
	reg  [15:0] line_cmd_q;
	reg  [6:0]  irq_stat_q;
	reg  [6:0]  irq_mask_q;
	wire [6:0]  status;

	// write and read strobes of the access phase
	wire wr_en = psel & penable & pwrite;
	wire rd_en = psel & penable & ~pwrite;

	// zero wait states and no error response keep the bus side trivial
	assign pready  = 1'b1;
	assign pslverr = 1'b0;

	// single-cycle access phase; the write lands at the edge that sees penable
	// writes to read-only or unmapped offsets are dropped without an error
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q       <= `WASC_CTRL_RST;
			dev_thr_q    <= `WASC_DEV_THR_RST;
			estop_time_q <= `WASC_ESTOP_TIME_RST;
			inch_spd_q   <= `WASC_INCH_SPD_RST;
			inch_acc_q   <= `WASC_INCH_ACC_RST;
			inch_dec_q   <= `WASC_INCH_DEC_RST;
			base_acc_q   <= `WASC_BASE_ACC_RST;
			base_dec_q   <= `WASC_BASE_DEC_RST;
			splice_q     <= `WASC_SPLICE_RST;
			max_spd_q    <= `WASC_MAX_SPD_RST;
			line_cmd_q   <= 16'h0000;
			irq_mask_q   <= 7'h00;
		end else if (wr_en) begin
			case (paddr)
				`WASC_CTRL_OFS:       ctrl_q       <= pwdata[3:0];
				`WASC_DEV_THR_OFS:    dev_thr_q    <= pwdata[15:0];
				`WASC_ESTOP_TIME_OFS: estop_time_q <= pwdata[19:0];
				`WASC_INCH_SPD_OFS:   inch_spd_q   <= pwdata[15:0];
				`WASC_INCH_ACC_OFS:   inch_acc_q   <= pwdata[19:0];
				`WASC_INCH_DEC_OFS:   inch_dec_q   <= pwdata[19:0];
				`WASC_BASE_ACC_OFS:   base_acc_q   <= pwdata[19:0];
				`WASC_BASE_DEC_OFS:   base_dec_q   <= pwdata[19:0];
				`WASC_SPLICE_OFS:     splice_q     <= pwdata[15:0];
				`WASC_MAX_SPD_OFS:    max_spd_q    <= pwdata[15:0];
				`WASC_LINE_CMD_OFS:   line_cmd_q   <= pwdata[15:0];
				`WASC_IRQ_MASK_OFS:   irq_mask_q   <= pwdata[6:0];
				default: ;
			endcase
		end
	end

	// read mux, registered so data comes from flip-flops
	// the word is captured in the setup cycle and stands through the access phase
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel & ~penable & ~pwrite) begin
			case (paddr)
				`WASC_CTRL_OFS:       prdata <= {28'h000_0000, ctrl_q};
				`WASC_DEV_THR_OFS:    prdata <= {16'h0000, dev_thr_q};
				`WASC_ESTOP_TIME_OFS: prdata <= {12'h000, estop_time_q};
				`WASC_INCH_SPD_OFS:   prdata <= {16'h0000, inch_spd_q};
				`WASC_INCH_ACC_OFS:   prdata <= {12'h000, inch_acc_q};
				`WASC_INCH_DEC_OFS:   prdata <= {12'h000, inch_dec_q};
				`WASC_BASE_ACC_OFS:   prdata <= {12'h000, base_acc_q};
				`WASC_BASE_DEC_OFS:   prdata <= {12'h000, base_dec_q};
				`WASC_SPLICE_OFS:     prdata <= {16'h0000, splice_q};
				`WASC_MAX_SPD_OFS:    prdata <= {16'h0000, max_spd_q};
				`WASC_LINE_CMD_OFS:   prdata <= {16'h0000, line_cmd_q};
				`WASC_STATUS_OFS:     prdata <= {25'h000_0000, status};
				`WASC_IRQ_STAT_OFS:   prdata <= {25'h000_0000, irq_stat_q};
				`WASC_IRQ_MASK_OFS:   prdata <= {25'h000_0000, irq_mask_q};
				`WASC_SPD_REF_OFS:    prdata <= {16'h0000, speed_ref};
				default:              prdata <= 32'h0000_0000;
			endcase
		end
	end

	// ****************************************************************
	// mode decode
	// ****************************************************************
	// emergency stop overrides inching; splicing is held off while inching
	wire estop_act  = estop_s;
	wire inch_act   = inch_s & ~estop_s;
	wire splice_act = splice_s & ~inch_s;

	// tension loop holds through the emergency ramp and after standstill
	assign tension_ctrl_run  = ~tinh_s;
	assign diameter_calc_run = ~inch_s;

	// ****************************************************************
	// line command with splice boost (0.1 percent units)
	// ****************************************************************
	// boost is a share of the command itself, so a zero command gets no boost
	wire [31:0] boost_prod = line_cmd_q * splice_q;
	wire [31:0] boost_div  = boost_prod / {16'h0000, `WASC_PCT_MAX};
	wire [16:0] final_cmd  = {1'b0, line_cmd_q} + (splice_act ? boost_div[16:0] : 17'h0_0000);
	// saturate rather than wrap if the boosted command overflows
	wire [15:0] final_sat  = final_cmd[16] ? 16'hFFFF : final_cmd[15:0];

	// ****************************************************************
	// deviation judgement with hysteresis
	// ****************************************************************
	// gap is a magnitude, so overspeed counts as well as underspeed
	wire [15:0] gap = (line_cmd_q > act_q) ? (line_cmd_q - act_q) : (act_q - line_cmd_q);
	// scale by 1000 so the gap compares to command times threshold in 0.1 percent
	wire [31:0] gap_pm   = gap * `WASC_PCT_MAX;
	wire [31:0] thr_hi   = line_cmd_q * dev_thr_q;
	// the release level floors at zero for thresholds inside the band
	wire [15:0] thr_lo_p = (dev_thr_q > `WASC_HYST_PCT) ? (dev_thr_q - `WASC_HYST_PCT) : 16'h0000;
	wire [31:0] thr_lo   = line_cmd_q * thr_lo_p;
	reg         dev_q;

	// set above threshold, release only below threshold minus the band
	// disabling the check drops the flag at once rather than waiting for the band
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dev_q <= 1'b0;
		end else if (!ctrl_q[`WASC_CTRL_DEV_EN]) begin
			dev_q <= 1'b0;
		end else if (gap_pm > thr_hi) begin
			dev_q <= 1'b1;
		end else if (gap_pm < thr_lo) begin
			dev_q <= 1'b0;
		end
	end

	// aux and open-collector outputs show the flag only when configured for it; the deviation output always shows it
	assign speed_deviation_output = dev_q;
	assign aux_output_one         = dev_q & ctrl_q[`WASC_CTRL_OUT1_DEV];
	assign open_collector_output  = dev_q & ctrl_q[`WASC_CTRL_OC_DEV];

	// ****************************************************************
	// ramp generator: full scale per selected time
	// ****************************************************************
	// inching speed is a share of the maximum motor speed
	wire [31:0] inch_prod = max_spd_q * inch_spd_q;
	wire [31:0] inch_div  = inch_prod / {16'h0000, `WASC_PCT_MAX};
	wire [15:0] target    = estop_act ? 16'h0000 : (inch_act ? inch_div[15:0] : final_sat);
	// inching takes its own ramp times only when the select bit is set
	wire        use_inch  = inch_act & ctrl_q[`WASC_CTRL_INCH_SEL];
	wire [19:0] acc_t     = use_inch ? inch_acc_q : base_acc_q;
	wire [19:0] dec_t     = use_inch ? inch_dec_q : base_dec_q;

	// the tick divides the clock down to the time unit of the ramp settings
	reg  [31:0] tick_cnt_q;
	reg  [15:0] start_q;
	reg  [19:0] elapsed_q;
	reg         estop_d1_q;
	wire        tick = (tick_cnt_q == TICK_CYC - 1);

	// emergency ramp runs from the speed at the moment of the stop, linear in time
	wire [35:0] estop_rem  = (elapsed_q >= estop_time_q) ? 36'h0_0000_0000 :
		{16'h0000, estop_time_q - elapsed_q} * {20'h0_0000, start_q};
	// a zero stop time means an immediate stop; the divide by zero is skipped
	wire [35:0] estop_val  = (estop_time_q == 20'h0_0000) ? 36'h0_0000_0000 :
		estop_rem / {16'h0000, estop_time_q};
	// step per tick is full scale over the ramp time, at least one count
	wire [19:0] step_t     = (target > speed_ref) ? acc_t : dec_t;
	wire [35:0] step_raw   = (step_t == 20'h0_0000) ? 36'h0_0000_FFFF :
		{20'h0_0000, max_spd_q} / {16'h0000, step_t};
	wire [15:0] step       = (step_raw[35:16] != 20'h0_0000) ? 16'hFFFF :
		((step_raw[15:0] == 16'h0000) ? 16'h0001 : step_raw[15:0]);
	wire [16:0] up_sum     = {1'b0, speed_ref} + {1'b0, step};

	// ramp register: emergency ramp first, then the normal ramp toward the target
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt_q <= 32'h0000_0000;
			speed_ref  <= 16'h0000;
			start_q    <= 16'h0000;
			elapsed_q  <= 20'h0_0000;
			estop_d1_q <= 1'b0;
		end else begin
			estop_d1_q <= estop_act;
			// restart the tick at the stop so the ramp lasts the set time, not up to a tick shorter
			if (estop_act && !estop_d1_q)
				tick_cnt_q <= 32'h0000_0000;
			else
				tick_cnt_q <= tick ? 32'h0000_0000 : tick_cnt_q + 32'h0000_0001;
			if (estop_act && !estop_d1_q) begin
				start_q   <= speed_ref;
				elapsed_q <= 20'h0_0000;
			end else if (estop_act) begin
				if (tick && elapsed_q < estop_time_q)
					elapsed_q <= elapsed_q + 20'h0_0001;
				speed_ref <= estop_val[15:0];
			end else if (tick) begin
				if (target > speed_ref)
					speed_ref <= (up_sum[15:0] > target || up_sum[16]) ? target : up_sum[15:0];
				else if (target < speed_ref)
					speed_ref <= (speed_ref - target < step) ? target : speed_ref - step;
			end
		end
	end

	// ****************************************************************
	// status and interrupts
	// ****************************************************************
	// status bits, top down: diameter run, tension run, splice, inching, stopped, stop, deviation
	assign status = {~inch_s,
		tension_ctrl_run,
		splice_act,
		inch_act,
		estop_act & (speed_ref == 16'h0000),
		estop_act,
		dev_q};
	reg [6:0] status_d1_q;

	// rising status bits are sticky; a new event wins over a write-one clear
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_d1_q <= `WASC_STATUS_RST;  // idle level of the pins, so reset raises no false event
			irq_stat_q  <= 7'h00;
		end else begin
			status_d1_q <= status;
			irq_stat_q  <= (irq_stat_q & ~((wr_en && paddr == `WASC_IRQ_STAT_OFS) ? pwdata[6:0] : 7'h00))
				| (status & ~status_d1_q);
		end
	end

	// one level interrupt, high while any unmasked sticky bit stands
	assign irq = |(irq_stat_q & irq_mask_q);
endmodule

//--- tb/wasc_top_assertions.sv
// pin-level assertions of the web aux speed control
`timescale 1ns/100ps
module wasc_top_assertions (
	input wire        pclk,
	input wire        presetn,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire        pready,
	input wire        pslverr,
	input wire        estop_in,
	input wire        inch_in,
	input wire        tension_loop_inhibit,
	input wire [15:0] speed_ref,
	input wire        speed_deviation_output,
	input wire        aux_output_one,
	input wire        open_collector_output,
	input wire        tension_ctrl_run,
	input wire        diameter_calc_run
);
	reg dev_en_q;
	// shadow of the enable bit; only a completed write to offset zero moves it
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			dev_en_q <= 1'b0;
		else if (psel && penable && pwrite && paddr == 12'h000 && pready)
			dev_en_q <= pwdata[0];
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ****************************************************************
	// properties
	// ****************************************************************
	sequence s_estop_held;
		estop_in [*2];
	endsequence
	sequence s_settled;
		$past(presetn, 3);
	endsequence
	property p_tension; s_settled |-> tension_ctrl_run == !$past(tension_loop_inhibit, 2); endproperty
	property p_diam; s_settled |-> diameter_calc_run == !$past(inch_in, 2); endproperty
	property p_aux; aux_output_one |-> speed_deviation_output; endproperty
	property p_oc; open_collector_output |-> speed_deviation_output; endproperty
	property p_ramp; s_estop_held ##3 1 |-> speed_ref <= $past(speed_ref); endproperty
	property p_ready; pready && !pslverr; endproperty
	property p_rdata; !$past(psel && !penable) |-> $stable(prdata); endproperty
	property p_dev_off; !dev_en_q && !$past(dev_en_q) && !$past(dev_en_q, 2) |-> !speed_deviation_output; endproperty
	a_tension: assert property (p_tension) else $error("tension run wrong");
	a_diam: assert property (p_diam) else $error("diameter run wrong");
	a_aux: assert property (p_aux) else $error("aux without deviation");
	a_oc: assert property (p_oc) else $error("oc without deviation");
	a_ramp: assert property (p_ramp) else $error("speed rose in stop");
	a_ready: assert property (p_ready) else $error("bus answer wrong");
	a_rdata: assert property (p_rdata) else $error("read data moved");
	a_dev_off: assert property (p_dev_off) else $error("deviation while off");
endmodule
bind wasc_top wasc_top_assertions chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
	.prdata, .pready, .pslverr, .estop_in, .inch_in, .tension_loop_inhibit, .speed_ref,
	.speed_deviation_output, .aux_output_one, .open_collector_output, .tension_ctrl_run, .diameter_calc_run);

//--- tb/wasc_line_ctrl.sv
// partner model: line controller driving the multi-function inputs
`timescale 1ns/100ps
module wasc_line_ctrl (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        estop_req,
	input  wire        inch_req,
	input  wire        splice_req,
	input  wire [15:0] speed_req,
	output reg         estop_in,
	output reg         inch_in,
	output reg         tension_loop_inhibit,
	output reg         splice_in,
	output reg  [15:0] line_speed_actual
);
	// pins move just after an edge, like the controller's output contacts
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			estop_in <= 1'b0;
			inch_in <= 1'b0;
			splice_in <= 1'b0;
			tension_loop_inhibit <= 1'b0;
			line_speed_actual <= 16'h0000;
		end else begin
			estop_in <= estop_req;
			inch_in <= inch_req;
			splice_in <= splice_req;
			tension_loop_inhibit <= splice_req;
			line_speed_actual <= speed_req;
		end
	end
endmodule

//--- tb/test_web_aux_speed_control.sv
// self-checking bench of the web aux speed control
`timescale 1ns/100ps
`include "wasc_map.vh"
module test_web_aux_speed_control;
	reg         pclk = 1'b0;
	reg         presetn = 1'b0;
	reg         psel = 1'b0;
	reg         penable = 1'b0;
	reg         pwrite = 1'b0;
	reg  [11:0] paddr = 12'h000;
	reg  [31:0] pwdata = 32'h0000_0000;
	reg         estop_req = 1'b0;
	reg         inch_req = 1'b0;
	reg         splice_req = 1'b0;
	reg  [15:0] speed_req = 16'h0000;
	wire [31:0] prdata;
	wire        pready, pslverr, estop_in, inch_in, tension_loop_inhibit, splice_in, irq;
	wire [15:0] line_speed_actual, speed_ref;
	wire        speed_deviation_output, aux_output_one, open_collector_output, tension_ctrl_run, diameter_calc_run;
	integer     failures = 0;
	integer     checks = 0;
	integer     n;
	integer     i;
	reg  [31:0] rd;
	// 4 ns clock
	always #2 pclk = ~pclk;
	// short tick keeps the ramps to a few dozen cycles
	wasc_top #(.TICK_CYC(4)) dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .estop_in, .inch_in, .tension_loop_inhibit, .splice_in, .line_speed_actual,
		.speed_ref, .speed_deviation_output, .aux_output_one, .open_collector_output, .tension_ctrl_run,
		.diameter_calc_run, .irq);
	wasc_line_ctrl ctl_u (.pclk, .presetn, .estop_req, .inch_req, .splice_req, .speed_req, .estop_in,
		.inch_in, .tension_loop_inhibit, .splice_in, .line_speed_actual);
	// ****************************************************************
	// helpers
	// ****************************************************************
	task conclude;
		begin
			$display("checks %0d failures %0d", checks, failures);
			if (failures == 0 && checks > 0)
				$display("NO MISMATCHES");
			else
				$display("MISMATCHES SEEN");
			$finish;
		end
	endtask
	task cmp_word(input [8*12:1] nm, input [31:0] e, input [31:0] g);
		begin
			checks = checks + 1;
			if (g !== e) begin
				failures = failures + 1;
				$display("CHECK FAILED %0s expected %h seen %h", nm, e, g);
			end
		end
	endtask
	task cmp_bit(input [8*12:1] nm, input e, input g);
		begin
			cmp_word(nm, {31'h0000_0000, e}, {31'h0000_0000, g});
		end
	endtask
	// one apb transfer, held until pready; entered just after an edge
	task apb(input w, input [11:0] a, input [31:0] d);
		begin
			psel <= 1'b1;
			penable <= 1'b0;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge pclk);
			penable <= 1'b1;
			@(posedge pclk);
			while (pready !== 1'b1)
				@(posedge pclk);
			rd = prdata;
			psel <= 1'b0;
			penable <= 1'b0;
			@(posedge pclk);
		end
	endtask
	task rd_chk(input [8*12:1] nm, input [11:0] a, input [31:0] e);
		begin
			apb(1'b0, a, 32'h0000_0000);
			cmp_word(nm, e, rd);
		end
	endtask
	// bounded wait; n is the number of cycles taken
	task wait_ref(input [15:0] v);
		begin
			n = 0;
			while (speed_ref !== v && n < 400) begin
				@(posedge pclk);
				n = n + 1;
			end
			if (speed_ref !== v) begin
				failures = failures + 1;
				$display("CHECK FAILED speed ref expected %h seen %h", v, speed_ref);
			end
		end
	endtask
	// inputs are seen a few cycles late, so settle before judging
	task dev_step(input [15:0] v, input e);
		begin
			speed_req <= v;
			repeat (8) @(posedge pclk);
			cmp_bit("deviation", e, speed_deviation_output);
			cmp_bit("aux", e, aux_output_one);
			cmp_bit("oc", e, open_collector_output);
		end
	endtask
	// ****************************************************************
	// scenarios
	// ****************************************************************
	task t_regs;
		begin
			rd_chk("ctrl", `WASC_CTRL_OFS, `WASC_CTRL_RST);
			rd_chk("threshold", `WASC_DEV_THR_OFS, `WASC_DEV_THR_RST);
			rd_chk("stop time", `WASC_ESTOP_TIME_OFS, `WASC_ESTOP_TIME_RST);
			rd_chk("inch speed", `WASC_INCH_SPD_OFS, `WASC_INCH_SPD_RST);
			rd_chk("inch acc", `WASC_INCH_ACC_OFS, `WASC_INCH_ACC_RST);
			rd_chk("inch dec", `WASC_INCH_DEC_OFS, `WASC_INCH_DEC_RST);
			rd_chk("splice", `WASC_SPLICE_OFS, `WASC_SPLICE_RST);
			rd_chk("irq mask", `WASC_IRQ_MASK_OFS, 32'h0000_0000);
			apb(1'b1, 12'h03C, 32'hFFFF_FFFF);
			rd_chk("unmapped", 12'h03C, 32'h0000_0000);
		end
	endtask
	// command 1000, threshold 10 percent: set above 100 off, clear below 80 off
	task t_dev;
		begin
			apb(1'b1, `WASC_LINE_CMD_OFS, 32'h0000_03E8);
			apb(1'b1, `WASC_DEV_THR_OFS, 32'h0000_0064);
			dev_step(16'h0352, 1'b0);
			apb(1'b1, `WASC_CTRL_OFS, 32'h0000_000F);
			dev_step(16'h0352, 1'b1);
			cmp_bit("irq masked", 1'b0, irq);
			apb(1'b1, `WASC_IRQ_MASK_OFS, 32'h0000_0001);
			cmp_bit("irq", 1'b1, irq);
			apb(1'b1, `WASC_IRQ_STAT_OFS, 32'h0000_0001);
			rd_chk("irq stat", `WASC_IRQ_STAT_OFS, 32'h0000_0000);
			cmp_bit("irq clear", 1'b0, irq);
			dev_step(16'h038E, 1'b1);
			dev_step(16'h0399, 1'b0);
			dev_step(16'h0442, 1'b0);
			dev_step(16'h0384, 1'b0);
			dev_step(16'h044D, 1'b1);
			cmp_bit("irq again", 1'b1, irq);
			apb(1'b1, `WASC_CTRL_OFS, 32'h0000_000E);
			dev_step(16'h044D, 1'b0);
		end
	endtask
	task t_inch;
		begin
			apb(1'b1, `WASC_LINE_CMD_OFS, 32'h0000_0000);
			apb(1'b1, `WASC_BASE_ACC_OFS, 32'h0000_000A);
			apb(1'b1, `WASC_BASE_DEC_OFS, 32'h0000_000A);
			apb(1'b1, `WASC_INCH_ACC_OFS, 32'h0000_001E);
			wait_ref(16'h0000);
			inch_req <= 1'b1;
			wait_ref(16'h012C);
			cmp_bit("inch ramp", 1'b1, n >= 8 && n <= 24);
			cmp_bit("diameter", 1'b0, diameter_calc_run);
			cmp_bit("tension", 1'b1, tension_ctrl_run);
			apb(1'b1, `WASC_CTRL_OFS, 32'h0000_000C);
			apb(1'b1, `WASC_INCH_SPD_OFS, 32'h0000_00C8);
			wait_ref(16'h0258);
			cmp_bit("base ramp", 1'b1, n <= 8);
			splice_req <= 1'b1;
			repeat (8) @(posedge pclk);
			apb(1'b0, `WASC_STATUS_OFS, 32'h0000_0000);
			cmp_bit("splice inch", 1'b0, rd[4]);
			cmp_bit("tension", 1'b0, tension_ctrl_run);
			inch_req <= 1'b0;
			repeat (8) @(posedge pclk);
			apb(1'b0, `WASC_STATUS_OFS, 32'h0000_0000);
			cmp_bit("splice", 1'b1, rd[4]);
			apb(1'b1, `WASC_SPLICE_OFS, 32'h0000_0064);
			apb(1'b1, `WASC_LINE_CMD_OFS, 32'h0000_01F4);
			wait_ref(16'h0226);
			cmp_word("splice ref", 32'h0000_0226, {16'h0000, speed_ref});
			splice_req <= 1'b0;
			apb(1'b1, `WASC_LINE_CMD_OFS, 32'h0000_0000);
		end
	endtask
	// stop time 0.2 s is 20 ticks of 4 cycles, from either speed
	task t_estop;
		begin
			apb(1'b1, `WASC_ESTOP_TIME_OFS, 32'h0000_0014);
			for (i = 0; i < 2; i = i + 1) begin
				apb(1'b1, `WASC_INCH_SPD_OFS, i ? 32'h0000_0064 : 32'h0000_00C8);
				inch_req <= 1'b1;
				wait_ref(i ? 16'h012C : 16'h0258);
				estop_req <= 1'b1;
				wait_ref(16'h0000);
				cmp_bit("stop time", 1'b1, n >= 76 && n <= 92);
				cmp_bit("tension", 1'b1, tension_ctrl_run);
				apb(1'b0, `WASC_STATUS_OFS, 32'h0000_0000);
				cmp_bit("stopped", 1'b1, rd[2]);
				inch_req <= 1'b0;
				estop_req <= 1'b0;
				repeat (4) @(posedge pclk);
			end
		end
	endtask
	// ****************************************************************
	// main sequence and watchdog
	// ****************************************************************
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs;
		t_dev;
		t_inch;
		t_estop;
		conclude;
	end
	// the tests need a few hundred cycles; far beyond that means a hang
	initial begin
		#100000;
		failures = failures + 1;
		conclude;
	end
endmodule
